// ==== design/sfs_cfg.svh ====
// Notes on behaviour
// R1: The adapter is only ever a slave, so it transmits only in reply to a received request.
// R2: Serving an ordinary request must finish within 20 ms of the request, or a late flag is set.
// R3: A request that changes a preset value may take up to 100 ms before it counts as late.
// R4: Override off: bit_rate_select 000/001/010/011 gives 4.8/9.6/19.2/38.4 kbps, 1xx gives 57.6.
// R5: Override off: stop_parity_select off gives two stops, no parity, on one stop plus parity.
// R6: parity_type_select picks odd when off, even when on, and counts only while parity is on.
// R7: default_format_override on ignores switches one to five: 38.4 kbps, two stops, no parity.
// R8: Switches are sampled after reset and the format applied before a first frame is taken.
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH

`define SFS_CLK_HZ 125000000
`define SFS_BIT_4800 (`SFS_CLK_HZ / 4800)
`define SFS_BIT_9600 (`SFS_CLK_HZ / 9600)
`define SFS_BIT_19200 (`SFS_CLK_HZ / 19200)
`define SFS_BIT_38400 (`SFS_CLK_HZ / 38400)
`define SFS_BIT_57600 (`SFS_CLK_HZ / 57600)

`define SFS_REQ_MS 20
`define SFS_PRESET_MS 100
`define SFS_REQ_CYC (`SFS_REQ_MS * (`SFS_CLK_HZ / 1000))
`define SFS_PRESET_CYC (`SFS_PRESET_MS * (`SFS_CLK_HZ / 1000))
`define SFS_SETTLE 3'h4

`define SFS_SW_RATE_HI 2
`define SFS_SW_STOP_PAR 3
`define SFS_SW_PAR_TYPE 4
`define SFS_SW_OVERRIDE 5

`define SFS_REG_CTRL 5'h00
`define SFS_REG_STATUS 5'h04
`define SFS_REG_RXDATA 5'h08
`define SFS_REG_TXDATA 5'h0c

`define SFS_CTRL_DONE 0
`define SFS_CTRL_PRESET 1
`define SFS_CTRL_RELOAD 2
`define SFS_ST_FLAG_LO 10

`define SFS_RESP_OKAY 2'h0
`define SFS_RESP_SLVERR 2'h2

`endif

// ==== design/sfs_pkg.sv ====
package sfs_pkg;
  typedef enum logic [2:0] {SFS_R4800, SFS_R9600, SFS_R19200, SFS_R38400, SFS_R57600} sfs_rate_t;
  typedef enum {SFS_IDLE, SFS_START, SFS_DATA, SFS_PAR, SFS_STOP} sfs_line_t;
endpackage

// ==== design/sfs_pair_buf.sv ====
`timescale 1ns/1ps
module sfs_pair_buf #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("sfs_pair_buf needs a power-of-two depth of at least two");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp;
  logic [AW:0] cnt;
  logic push, pop;

  assign in_ready = cnt != FULL;
  assign out_valid = cnt != '0;
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  a_buf_bound: assert property (@(posedge core_clk) disable iff (!nrst) cnt <= FULL)
    else $error("buffer count above depth");
  a_buf_keeps_word: assert property (@(posedge core_clk) disable iff (!nrst)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled word lost or changed");
endmodule

// ==== design/sfs_top.sv ====
`timescale 1ns/1ps
`include "sfs_cfg.svh"
module sfs_top #(
  parameter int unsigned REQ_LIMIT = `SFS_REQ_CYC,
  parameter int unsigned PRESET_LIMIT = `SFS_PRESET_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Configuration switches
  input wire logic [7:0] format_switch_bank,
  // RS-485 line
  input wire logic rx_pin,
  output logic tx_pin,
  output logic tx_oe,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [4:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [4:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  import sfs_pkg::*;

  if (REQ_LIMIT < 1 || PRESET_LIMIT < 1 || (REQ_LIMIT | PRESET_LIMIT) >= 2**24) begin : g_chk
    $error("sfs_top limits must lie between 1 and 2**24-1");
  end

  logic [7:0] sw_s1, sw_s2;
  logic rx_s1, rx_s2;
  logic [2:0] settle;
  logic cfg_ok, par_en, par_even, two_stop;
  sfs_rate_t rate;
  logic [15:0] bit_cyc;

  // Both the line and the switches are asynchronous to core_clk.
  always_ff @(posedge core_clk) begin
    sw_s1 <= format_switch_bank;
    sw_s2 <= sw_s1;
    rx_s1 <= rx_pin;
    rx_s2 <= rx_s1;
  end

  always_comb begin
    case (rate)
      SFS_R4800: bit_cyc = 16'(`SFS_BIT_4800);
      SFS_R9600: bit_cyc = 16'(`SFS_BIT_9600);
      SFS_R19200: bit_cyc = 16'(`SFS_BIT_19200);
      SFS_R57600: bit_cyc = 16'(`SFS_BIT_57600);
      default: bit_cyc = 16'(`SFS_BIT_38400);
    endcase
  end

  // AXI write capture.
  logic aw_held, w_held, wr_lane0, do_wr;
  logic [4:0] wr_addr;
  logic [31:0] wr_data;
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign do_wr = aw_held && w_held && !bvalid;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 5'h00;
      wr_data <= 32'h0;
      wr_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `SFS_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wr_data <= wdata;
        wr_lane0 <= wstrb[0];
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (wr_addr == `SFS_REG_CTRL || wr_addr == `SFS_REG_STATUS ||
                  wr_addr == `SFS_REG_TXDATA || wr_addr == `SFS_REG_RXDATA) ?
                 `SFS_RESP_OKAY : `SFS_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  logic wr_ctrl, wr_status, wr_tx, reload_req, reply_done;
  sfs_line_t rx_st, tx_st;
  always_comb begin
    wr_ctrl = 1'b0;
    wr_status = 1'b0;
    wr_tx = 1'b0;
    if (do_wr && wr_lane0 && wr_addr == `SFS_REG_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (do_wr && wr_lane0 && wr_addr == `SFS_REG_STATUS) begin
      wr_status = 1'b1;
    end else if (do_wr && wr_lane0 && wr_addr == `SFS_REG_TXDATA) begin
      wr_tx = 1'b1;
    end
  end
  assign reply_done = wr_ctrl && wr_data[`SFS_CTRL_DONE];
  // A reload mid-frame would change the bit period under a running byte, so it is dropped unless rx_st and tx_st are both idle.
  assign reload_req = wr_ctrl && wr_data[`SFS_CTRL_RELOAD] && rx_st == SFS_IDLE &&
                      tx_st == SFS_IDLE;

  // Switch sampling after reset; the receiver stays closed until cfg_ok.
  always_ff @(posedge core_clk) begin
    if (!nrst || reload_req) begin
      settle <= 3'h0;
      cfg_ok <= 1'b0;
    end else if (!cfg_ok) begin
      if (settle == `SFS_SETTLE) begin
        cfg_ok <= 1'b1; // R8
      end else begin
        settle <= settle + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rate <= SFS_R38400;
      par_en <= 1'b0;
      par_even <= 1'b0;
      two_stop <= 1'b1;
    end else if (!cfg_ok && settle == `SFS_SETTLE) begin
      if (sw_s2[`SFS_SW_OVERRIDE]) begin
        rate <= SFS_R38400; // R7
        par_en <= 1'b0;
        par_even <= 1'b0;
        two_stop <= 1'b1;
      end else begin
        if (sw_s2[`SFS_SW_RATE_HI]) begin
          rate <= SFS_R57600; // R4
        end else begin
          rate <= sfs_rate_t'({1'b0, sw_s2[1:0]}); // R4
        end
        par_en <= sw_s2[`SFS_SW_STOP_PAR]; // R5
        two_stop <= !sw_s2[`SFS_SW_STOP_PAR]; // R5
        par_even <= sw_s2[`SFS_SW_STOP_PAR] && sw_s2[`SFS_SW_PAR_TYPE]; // R6
      end
    end
  end

  // Receiver: samples mid-bit, checks the first stop bit only.
  logic [15:0] rx_cnt;
  logic [2:0] rx_bit;
  logic [7:0] rx_sh;
  logic rx_par, rx_done, rx_ferr, rx_perr;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_st <= SFS_IDLE;
      rx_cnt <= 16'h0;
      rx_bit <= 3'h0;
      rx_sh <= 8'h0;
      rx_par <= 1'b0;
    end else begin
      case (rx_st)
        SFS_IDLE: begin
          if (cfg_ok && !rx_s2) begin // R8
            rx_st <= SFS_START;
            rx_cnt <= bit_cyc >> 1;
          end
        end
        SFS_START: begin
          if (rx_cnt != 16'h0) begin
            rx_cnt <= rx_cnt - 16'h1;
          end else if (!rx_s2) begin
            rx_st <= SFS_DATA;
            rx_cnt <= bit_cyc - 16'h1;
            rx_bit <= 3'h0;
            rx_par <= 1'b0;
          end else begin
            rx_st <= SFS_IDLE;
          end
        end
        SFS_DATA, SFS_PAR: begin
          if (rx_cnt != 16'h0) begin
            rx_cnt <= rx_cnt - 16'h1;
          end else begin
            rx_cnt <= bit_cyc - 16'h1;
            rx_par <= rx_par ^ rx_s2;
            if (rx_st == SFS_PAR) begin
              rx_st <= SFS_STOP;
            end else begin
              rx_sh <= {rx_s2, rx_sh[7:1]};
              rx_bit <= rx_bit + 3'h1;
              if (rx_bit == 3'h7) begin
                rx_st <= par_en ? SFS_PAR : SFS_STOP; // R5
              end
            end
          end
        end
        default: begin
          if (rx_cnt != 16'h0) begin
            rx_cnt <= rx_cnt - 16'h1;
          end else begin
            rx_st <= SFS_IDLE;
          end
        end
      endcase
    end
  end
  assign rx_done = rx_st == SFS_STOP && rx_cnt == 16'h0;
  assign rx_ferr = rx_done && !rx_s2;
  // Odd parity leaves the running sum at one, even parity at zero.
  assign rx_perr = rx_done && par_en && (rx_par == par_even); // R6

  logic buf_in_ready, buf_out_valid, rx_pop;
  logic [7:0] buf_out_data;
  sfs_pair_buf #(.W(8), .DEPTH(2)) u_rx_buf (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_valid(rx_done && !rx_ferr),
    .in_ready(buf_in_ready),
    .in_data(rx_sh),
    .out_valid(buf_out_valid),
    .out_ready(rx_pop),
    .out_data(buf_out_data)
  );

  // Reply permission and scan-time watchdog.
  logic permit, preset_mode, late_now;
  logic [23:0] wd_cnt, wd_lim;
  assign wd_lim = preset_mode ? 24'(PRESET_LIMIT) : 24'(REQ_LIMIT); // R3
  // A switch of preset_mode mid-reply can leave the count above the new limit, hence >=.
  assign late_now = permit && wd_cnt >= wd_lim; // R2
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      permit <= 1'b0;
      wd_cnt <= 24'h0;
      preset_mode <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        preset_mode <= wr_data[`SFS_CTRL_PRESET];
      end
      if (reply_done) begin
        permit <= 1'b0;
        wd_cnt <= 24'h0;
      end else begin
        if (rx_done && !rx_ferr) begin
          permit <= 1'b1; // R1
        end
        if (permit && !late_now) begin
          wd_cnt <= wd_cnt + 24'h1;
        end
      end
    end
  end

  // Transmitter: only a reply may be sent, never an unsolicited frame.
  logic tx_go, tx_refused;
  logic [15:0] tx_cnt;
  logic [2:0] tx_bit;
  logic [7:0] tx_sh;
  logic tx_par, tx_stop2;
  assign tx_go = wr_tx && permit && cfg_ok && tx_st == SFS_IDLE; // R1
  assign tx_refused = wr_tx && !tx_go;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_st <= SFS_IDLE;
      tx_cnt <= 16'h0;
      tx_bit <= 3'h0;
      tx_sh <= 8'h0;
      tx_par <= 1'b0;
      tx_stop2 <= 1'b0;
      tx_pin <= 1'b1;
      tx_oe <= 1'b0;
    end else begin
      if (tx_st != SFS_IDLE && tx_cnt != 16'h0) begin
        tx_cnt <= tx_cnt - 16'h1;
      end else begin
        case (tx_st)
          SFS_IDLE: begin
            if (tx_go) begin
              tx_st <= SFS_START;
              tx_sh <= wr_data[7:0];
              tx_par <= !par_even;
              tx_stop2 <= two_stop; // R5
              tx_pin <= 1'b0;
              tx_oe <= 1'b1;
              tx_cnt <= bit_cyc - 16'h1;
            end
          end
          SFS_START, SFS_DATA: begin
            tx_cnt <= bit_cyc - 16'h1;
            if (tx_st == SFS_START || tx_bit != 3'h7) begin
              if (tx_st == SFS_DATA) begin
                tx_bit <= tx_bit + 3'h1;
              end
              tx_st <= SFS_DATA;
              tx_pin <= tx_sh[0];
              tx_par <= tx_par ^ tx_sh[0];
              tx_sh <= {1'b0, tx_sh[7:1]};
            end else if (par_en) begin
              tx_st <= SFS_PAR;
              tx_pin <= tx_par; // R6
            end else begin
              tx_st <= SFS_STOP;
              tx_pin <= 1'b1;
            end
          end
          SFS_PAR: begin
            tx_st <= SFS_STOP;
            tx_pin <= 1'b1;
            tx_cnt <= bit_cyc - 16'h1;
          end
          default: begin
            if (tx_stop2) begin
              tx_stop2 <= 1'b0;
              tx_cnt <= bit_cyc - 16'h1;
            end else begin
              tx_st <= SFS_IDLE;
              tx_oe <= 1'b0;
              tx_bit <= 3'h0;
            end
          end
        endcase
      end
    end
  end

  // Sticky flags: late, parity error, framing error, overrun, refused send. Set beats clear.
  logic [4:0] flags, flag_set;
  assign flag_set = {tx_refused, rx_done && !rx_ferr && !buf_in_ready, rx_ferr, rx_perr,
                     late_now};
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      flags <= 5'h00;
    end else begin
      flags <= (flags & ~(wr_status ? wr_data[`SFS_ST_FLAG_LO +: 5] : 5'h00)) | flag_set;
    end
  end

  // AXI read.
  assign arready = !rvalid;
  assign rx_pop = arvalid && arready && araddr == `SFS_REG_RXDATA;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `SFS_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `SFS_RESP_OKAY;
      if (araddr == `SFS_REG_CTRL) begin
        rdata <= {30'h0, preset_mode, 1'b0};
      end else if (araddr == `SFS_REG_STATUS) begin
        rdata <= {17'h0, flags, permit, tx_st != SFS_IDLE, buf_out_valid, cfg_ok, two_stop,
                  par_even, par_en, 3'(rate)};
      end else if (araddr == `SFS_REG_RXDATA) begin
        rdata <= {23'h0, buf_out_valid, buf_out_data};
      end else if (araddr == `SFS_REG_TXDATA) begin
        rdata <= 32'h0;
      end else begin
        rdata <= 32'h0;
        rresp <= `SFS_RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  a_only_reply: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(tx_oe) |-> $past(permit)) else $error("frame sent without a request"); // R1
  a_late_req: assert property (@(posedge core_clk) disable iff (!nrst)
    permit && !preset_mode && wd_cnt == 24'(REQ_LIMIT) && !reply_done |=> flags[0])
    else $error("ordinary late reply not flagged"); // R2
  a_late_preset: assert property (@(posedge core_clk) disable iff (!nrst)
    permit && preset_mode && wd_cnt < 24'(PRESET_LIMIT) |-> !late_now)
    else $error("preset reply flagged too early"); // R3
  a_rate_high: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(cfg_ok) && !$past(sw_s2[5]) && $past(sw_s2[2]) |-> rate == SFS_R57600)
    else $error("high rate pattern not decoded"); // R4
  a_frame_sel: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(cfg_ok) && !$past(sw_s2[5]) |-> par_en == $past(sw_s2[3]) && two_stop != par_en)
    else $error("stop and parity not decoded"); // R5
  a_par_type: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(cfg_ok) && !$past(sw_s2[5]) && $past(sw_s2[3]) |-> par_even == $past(sw_s2[4]))
    else $error("parity type not decoded"); // R6
  a_override: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(cfg_ok) && $past(sw_s2[5]) |-> rate == SFS_R38400 && two_stop && !par_en)
    else $error("override format wrong"); // R7
  a_rx_after_cfg: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(rx_st) == SFS_IDLE && rx_st == SFS_START |-> $past(cfg_ok))
    else $error("receiver started before configuration"); // R8
endmodule

// ==== tb/sfs_master_model.sv ====
`timescale 1ns/1ps
module sfs_master_model #(
  parameter int BIT = 2170
) (
  // Clock
  input wire logic core_clk,
  // RS-485 line
  output logic line_to_slave,
  input wire logic tx_pin,
  input wire logic tx_oe
);
  initial line_to_slave = 1'h1;

  // Only this side opens a frame; the slave may only answer it.
  // Returns at mid stop bit so the caller can time the reply watchdog closely.
  task automatic send_byte(input logic [7:0] d, input logic even);
    logic [10:0] f;
    f = {1'h1, even ? ^d : ~^d, d, 1'h0};
    for (int i = 0; i < 11; i++) begin
      line_to_slave <= f[i];
      repeat (i == 10 ? BIT / 2 : BIT) @(posedge core_clk);
    end
  endtask

  // Sampling on the falling edge keeps clear of the edge that moves the pin.
  task automatic recv_byte(output logic [7:0] d, output logic p, output logic s,
                           output logic oe, output logic f);
    int n;
    n = 0;
    while (!(tx_oe && !tx_pin) && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    f = (n < 1000);
    repeat (BIT / 2) @(negedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(negedge core_clk);
      d[i] = tx_pin;
    end
    repeat (BIT) @(negedge core_clk);
    p = tx_pin;
    repeat (BIT) @(negedge core_clk);
    s = tx_pin && tx_oe;
    repeat (BIT) @(negedge core_clk);
    oe = tx_oe;
  endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "sfs_cfg.svh"
module tb_top;
  import sfs_pkg::*;
  logic core_clk, nrst, rx_pin, tx_pin, tx_oe;
  logic [7:0] format_switch_bank;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int errors, checks_done, cycles;
  logic [7:0] sw_tab [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h08, 8'h18,
                              8'h10, 8'h3f, 8'hc2};
  logic [6:0] st_tab [11] = '{7'h60, 7'h61, 7'h62, 7'h63, 7'h64, 7'h64, 7'h48, 7'h58,
                              7'h60, 7'h63, 7'h62};

  sfs_top #(.REQ_LIMIT(200), .PRESET_LIMIT(1000)) sfs_top_inst (
    .core_clk(core_clk), .nrst(nrst), .format_switch_bank(format_switch_bank),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_oe(tx_oe),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  sfs_master_model #(.BIT(`SFS_BIT_57600)) sfs_master_model_inst (
    .core_clk(core_clk), .line_to_slave(rx_pin), .tx_pin(tx_pin), .tx_oe(tx_oe));

  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 100000) begin
      errors++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Handshakes are judged at the falling edge, where the ready lines have settled.
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] rs);
    int n;
    logic ah, wh, bh;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    bh = 1'h0;
    while (!bh && n < 100) begin
      @(negedge core_clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      rs = bresp;
      @(posedge core_clk);
      if (ah) awvalid <= 1'h0;
      if (wh) wvalid <= 1'h0;
      if (bh) bready <= 1'h0;
      n++;
    end
    // One idle edge keeps a following call from re-driving bready in the same step.
    @(posedge core_clk);
    if (!bh) chk("write answer", 32'h0, 32'h1);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    logic ah, rh;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    rh = 1'h0;
    while (!rh && n < 100) begin
      @(negedge core_clk);
      ah = arvalid && arready;
      rh = rvalid && rready;
      d = rdata;
      rs = rresp;
      @(posedge core_clk);
      if (ah) arvalid <= 1'h0;
      if (rh) rready <= 1'h0;
      n++;
    end
    @(posedge core_clk);
    if (!rh) chk("read answer", 32'h0, 32'h1);
  endtask

  task automatic reload(input logic [7:0] sw);
    format_switch_bank <= sw;
    cyc(4);
    wr(`SFS_REG_CTRL, 32'h4, r);
    cyc(12);
  endtask

  task automatic t_start;
    cyc(10);
    rd(`SFS_REG_STATUS, v, r);
    chk("start format", {25'h0, v[6:0]}, 32'h63);
    chk("idle line", {30'h0, tx_oe, tx_pin}, 32'h1);
  endtask

  task automatic t_formats;
    foreach (sw_tab[i]) begin
      reload(sw_tab[i]);
      rd(`SFS_REG_STATUS, v, r);
      chk("format", {25'h0, v[6:0]}, {25'h0, st_tab[i]});
    end
  endtask

  task automatic t_bus;
    rd(5'h10, v, r);
    chk("unmapped read", {30'h0, r}, 32'h2);
    wr(5'h14, 32'hffffffff, r);
    chk("unmapped write", {30'h0, r}, 32'h2);
    rd(`SFS_REG_TXDATA, v, r);
    chk("txdata read", {r, v[29:0]}, 32'h0);
  endtask

  // Without a request from the master the slave must never drive the line.
  task automatic t_refuse;
    logic seen;
    seen = 1'h0;
    wr(`SFS_REG_TXDATA, 32'h55, r);
    repeat (40) begin
      @(negedge core_clk);
      seen = seen | tx_oe;
    end
    @(posedge core_clk);
    chk("unasked tx", {31'h0, seen}, 32'h0);
    rd(`SFS_REG_STATUS, v, r);
    chk("tx refused", {31'h0, v[14]}, 32'h1);
    wr(`SFS_REG_STATUS, 32'h4000, r);
    rd(`SFS_REG_STATUS, v, r);
    chk("refused clear", {31'h0, v[14]}, 32'h0);
  endtask

  task automatic t_link;
    logic [7:0] d;
    logic p, s, oe, f;
    reload(8'h1c);
    sfs_master_model_inst.send_byte(8'ha5, 1'h1);
    cyc(100);
    rd(`SFS_REG_STATUS, v, r);
    chk("permit early", {30'h0, v[10:9]}, 32'h1);
    cyc(200);
    rd(`SFS_REG_STATUS, v, r);
    chk("late ordinary", {31'h0, v[10]}, 32'h1);
    rd(`SFS_REG_RXDATA, v, r);
    chk("rx byte", v, 32'h1a5);
    fork
      wr(`SFS_REG_TXDATA, 32'h3c, r);
      sfs_master_model_inst.recv_byte(d, p, s, oe, f);
    join
    @(posedge core_clk);
    chk("tx byte", {23'h0, f, d}, 32'h13c);
    chk("tx parity", {31'h0, p}, 32'h0);
    chk("tx stop", {30'h0, s, oe}, 32'h2);
    wr(`SFS_REG_CTRL, 32'h1, r);
    wr(`SFS_REG_STATUS, 32'h400, r);
    rd(`SFS_REG_STATUS, v, r);
    chk("reply closed", {30'h0, v[10:9]}, 32'h0);
  endtask

  task automatic t_preset;
    // Odd parity here, so the even-parity byte below must raise the parity flag.
    reload(8'h0c);
    wr(`SFS_REG_CTRL, 32'h2, r);
    sfs_master_model_inst.send_byte(8'h0f, 1'h1);
    cyc(300);
    rd(`SFS_REG_STATUS, v, r);
    chk("preset not late", {29'h0, v[11:9]}, 32'h5);
    cyc(800);
    rd(`SFS_REG_STATUS, v, r);
    chk("preset late", {31'h0, v[10]}, 32'h1);
    rd(`SFS_REG_CTRL, v, r);
    chk("preset mode", v & 32'h2, 32'h2);
    rd(`SFS_REG_RXDATA, v, r);
    chk("rx byte 2", v, 32'h10f);
  endtask

  initial begin
    nrst = 1'h0;
    format_switch_bank = 8'h2c;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 5'h0;
    araddr = 5'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (4) @(posedge core_clk);
    nrst <= 1'h1;
    t_start();
    t_formats();
    t_bus();
    t_refuse();
    t_link();
    t_preset();
    test_done();
  end
endmodule
